/* File: logic/mdfs_pkg.sv */
// Purpose: Constants for the motor driver fault status register bank.
// Assumes: Registers are 32 bits wide and addressed by an 8-bit register offset.
// Notes:   Field positions are bit indices within each register.
package mdfs_pkg;

	localparam int          REG_W                    = 32;
	localparam int          ADDR_W                   = 8;
	localparam logic [7:0]  ADDR_POWER_STAGE_FAULT   = 8'hE0;
	localparam logic [7:0]  ADDR_CONTROL_LOOP_FAULT  = 8'hE2;
	localparam logic [7:0]  ADDR_SYSTEM_STATUS_ONE   = 8'hE4;
	localparam logic [7:0]  ADDR_ALGO_CONTROL        = 8'hE6;
	localparam logic [7:0]  ADDR_SYSTEM_STATUS_TWO   = 8'hEA;
	localparam logic [7:0]  ADDR_SYSTEM_STATUS_THREE = 8'hEC;
	localparam logic [31:0] FAULT_RESET_VALUE        = 32'h00000000;

	// Power-stage fault register fields.
	localparam int PS_DRIVER_FAULT  = 31;
	localparam int PS_REG_FAULT     = 30;
	localparam int PS_OC_ANY        = 28;
	localparam int PS_POR_INV       = 27;
	localparam int PS_OVERVOLT      = 26;
	localparam int PS_THERMAL_ANY   = 25;
	localparam int PS_THERMAL_WARN  = 23;
	localparam int PS_THERMAL_SHUT  = 22;
	localparam int PS_OC_SW_HI      = 21;
	localparam int PS_OC_SW_LO      = 16;
	localparam int PS_MEM_ERR       = 14;
	localparam int PS_REG_OC        = 13;
	localparam int PS_REG_UV        = 12;
	localparam int PS_CP_UV         = 11;

	// Control-loop fault register fields.
	localparam int CL_CTRL_FAULT    = 31;
	localparam int CL_POS_FREQ      = 29;
	localparam int CL_POS_T1        = 28;
	localparam int CL_POS_T2        = 27;
	localparam int CL_ABNORMAL_SPEED_LOCK     = 23;
	localparam int CL_SYNC_LOST     = 22;
	localparam int CL_MOTOR_ABSENT  = 21;
	localparam int CL_LOCK_ANY      = 20;
	localparam int CL_CYCLE_ILIM    = 19;
	localparam int CL_LOCK_ILIM     = 18;
	localparam int CL_MOTOR_UV      = 17;
	localparam int CL_MOTOR_OV      = 16;
	localparam int CL_WDOG_TIMEOUT  = 15;
	localparam int CL_SELFTEST_EN   = 2;
	localparam int CL_SELFTEST_PASS = 1;
	localparam int CL_APP_RESET_OK  = 0;

	// Clear-all-faults command bit of the algorithm control register.
	localparam int ALGO_CLEAR_FAULTS = 29;

	localparam int NUM_PS_FLAGS = 14;
	localparam int NUM_CL_FLAGS = 12;

endpackage : mdfs_pkg

/* File: logic/mdfs_fault_status.sv */
// Purpose: Read-only fault status register bank of a three-phase motor driver.
// Assumes: Fault conditions arrive as asynchronous levels and are synchronised here.
// Notes:   The serial port engine presents a register offset with read and write strobes.
//
// Summary of operation
// - Power-stage top bit ORs all power faults.
// - Regulator fault flag reports any regulator fault.
// - Aggregate overcurrent flag for output stage.
// - Supply POR flag reads zero when detected.
// - Supply overvoltage flag reads one when detected.
// - Thermal flag ORs warning and shutdown.
// - Separate thermal warning and shutdown flags.
// - Six per-switch overcurrent flags, phase C first.
// - Programmable memory error flag.
// - Regulator overcurrent, undervoltage, charge pump flags.
// - Controller top bit ORs all controller faults.
// - Three position detection fault flags.
// - Abnormal speed and sync lost lock flags.
// - Motor absent flag; lock flag ORs abnormal speed, sync lost, motor absent and cycle current limit.
// - Cycle and lock current limit flags.
// - Motor undervoltage and overvoltage flags.
// - Host watchdog timeout flag.
// - Self-test enable mirrored read-only.
// - Self-test result, one means pass.
// - Application reset result in bit zero.
// - Read-only registers, zero reset, reserved zero.
// - Clear-faults write clears all fault flags whose condition has gone.

`timescale 1ns/1ns

module mdfs_fault_status
	import mdfs_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Register port from the serial engine.
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic              regRead,
	input  wire logic              regWrite,
	input  wire logic [REG_W-1:0]  regWdata,
	output logic      [REG_W-1:0]  regRdata,
	output logic                   regRvalid,
	// Power-stage fault conditions.
	input  wire logic              supplyPorDetect,
	input  wire logic              supplyOvervoltage,
	input  wire logic              thermalWarning,
	input  wire logic              thermalShutdown,
	input  wire logic [5:0]        overcurrentSwitch,
	input  wire logic              otpMemoryError,
	input  wire logic              regulatorOvercurrent,
	input  wire logic              regulatorUndervoltage,
	input  wire logic              chargePumpUndervoltage,
	// Controller fault conditions.
	input  wire logic              positionDetectFreqFault,
	input  wire logic              positionDetectTiming1Fault,
	input  wire logic              positionDetectTiming2Fault,
	input  wire logic              abnormalSpeedLock,
	input  wire logic              syncLostLock,
	input  wire logic              motorAbsentFault,
	input  wire logic              cycleCurrentLimitFault,
	input  wire logic              lockCurrentLimitFault,
	input  wire logic              motorUndervoltageFault,
	input  wire logic              motorOvervoltageFault,
	input  wire logic              hostWatchdogTimeout,
	// Self-test and reset status levels.
	input  wire logic              selftestEnabledCfg,
	input  wire logic              selftestPass,
	input  wire logic              appResetOk,
	// Extra status registers supplied by other blocks.
	input  wire logic [REG_W-1:0]  systemStatusOne,
	input  wire logic [REG_W-1:0]  systemStatusTwo,
	input  wire logic [REG_W-1:0]  systemStatusThree,
	output logic                   clearAllFaultsPulse
);

	localparam int NUM_IN = NUM_PS_FLAGS + NUM_CL_FLAGS + 3;

	//--------------------------------------------------------------------
	// Condition slots
	//--------------------------------------------------------------------
	// Power-stage conditions fill the low slots, slot 14 is a spare that
	// always reads 0, and the three live mirrors sit above the fault slots.
	localparam int FL_CP_UV        = 0;
	localparam int FL_REG_UV       = 1;
	localparam int FL_REG_OC       = 2;
	localparam int FL_MEM_ERR      = 3;
	localparam int FL_SW_LO        = 4;
	localparam int FL_SW_HI        = 9;
	localparam int FL_THERM_SHUT   = 10;
	localparam int FL_THERM_WARN   = 11;
	localparam int FL_OVERVOLT     = 12;
	localparam int FL_POR          = 13;
	localparam int FL_SPARE        = 14;
	localparam int FL_WDOG         = 15;
	localparam int FL_MOTOR_OV     = 16;
	localparam int FL_MOTOR_UV     = 17;
	localparam int FL_LOCK_ILIM    = 18;
	localparam int FL_CYCLE_ILIM   = 19;
	localparam int FL_MOTOR_ABSENT = 20;
	localparam int FL_SYNC_LOST    = 21;
	localparam int FL_ABNORMAL_SPEED_LOCK    = 22;
	localparam int FL_POS_T2       = 23;
	localparam int FL_POS_T1       = 24;
	localparam int FL_POS_FREQ     = 25;
	localparam int FL_APP_OK       = 26;
	localparam int FL_ST_PASS      = 27;
	localparam int FL_ST_EN        = 28;

	//--------------------------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------------------------
	logic [NUM_IN-1:0] rawIn;
	logic [NUM_IN-1:0] syncA_q;
	logic [NUM_IN-1:0] syncA_d;
	logic [NUM_IN-1:0] syncB_q;
	logic [NUM_IN-1:0] syncB_d;

	// Every slot is filled from its pin; the spare slot stays low.
	always_comb begin
		rawIn                    = '0;
		rawIn[FL_CP_UV]          = chargePumpUndervoltage;
		rawIn[FL_REG_UV]         = regulatorUndervoltage;
		rawIn[FL_REG_OC]         = regulatorOvercurrent;
		rawIn[FL_MEM_ERR]        = otpMemoryError;
		rawIn[FL_SW_HI:FL_SW_LO] = overcurrentSwitch;
		rawIn[FL_THERM_SHUT]     = thermalShutdown;
		rawIn[FL_THERM_WARN]     = thermalWarning;
		rawIn[FL_OVERVOLT]       = supplyOvervoltage;
		rawIn[FL_POR]            = supplyPorDetect;
		rawIn[FL_WDOG]           = hostWatchdogTimeout;
		rawIn[FL_MOTOR_OV]       = motorOvervoltageFault;
		rawIn[FL_MOTOR_UV]       = motorUndervoltageFault;
		rawIn[FL_LOCK_ILIM]      = lockCurrentLimitFault;
		rawIn[FL_CYCLE_ILIM]     = cycleCurrentLimitFault;
		rawIn[FL_MOTOR_ABSENT]   = motorAbsentFault;
		rawIn[FL_SYNC_LOST]      = syncLostLock;
		rawIn[FL_ABNORMAL_SPEED_LOCK]      = abnormalSpeedLock;
		rawIn[FL_POS_T2]         = positionDetectTiming2Fault;
		rawIn[FL_POS_T1]         = positionDetectTiming1Fault;
		rawIn[FL_POS_FREQ]       = positionDetectFreqFault;
		rawIn[FL_APP_OK]         = appResetOk;
		rawIn[FL_ST_PASS]        = selftestPass;
		rawIn[FL_ST_EN]          = selftestEnabledCfg;
	end

	always_comb begin
		syncA_d = rawIn;
		syncB_d = syncA_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
		end
	end

	//--------------------------------------------------------------------
	// Sticky fault flags
	//--------------------------------------------------------------------
	localparam int NUM_FLAGS = NUM_PS_FLAGS + NUM_CL_FLAGS;
	// Reset is itself a power-on event, so the supply reset flag starts set.
	localparam logic [NUM_FLAGS-1:0] FLAGS_AT_RESET = NUM_FLAGS'(1) << FL_POR;

	logic [NUM_FLAGS-1:0] cond;
	logic [NUM_FLAGS-1:0] flags_q;
	logic [NUM_FLAGS-1:0] flags_d;
	logic                 clearCmd;
	logic                 selftestEn;
	logic                 selftestOk;
	logic                 appOk;

	assign cond       = syncB_q[NUM_FLAGS-1:0];
	assign selftestEn = syncB_q[FL_ST_EN];
	assign selftestOk = syncB_q[FL_ST_PASS];
	assign appOk      = syncB_q[FL_APP_OK];

	assign clearCmd = regWrite && (regAddr == ADDR_ALGO_CONTROL)
	                  && regWdata[ALGO_CLEAR_FAULTS];

	always_comb begin
		flags_d = flags_q;
		if (clearCmd) begin
			flags_d = '0;
		end else begin
			flags_d = flags_q;
		end
		// A condition still present in the clear cycle re-sets its flag.
		flags_d = flags_d | cond;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_q <= FLAGS_AT_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	//--------------------------------------------------------------------
	// Register images
	//--------------------------------------------------------------------
	logic [REG_W-1:0] psImage;
	logic [REG_W-1:0] clImage;
	logic             psAny;
	logic             clAny;
	logic             lockAny;
	logic             regAny;
	logic             thermAny;
	logic             ocAny;

	always_comb begin
		ocAny    = |flags_q[FL_SW_HI:FL_SW_LO];
		thermAny = flags_q[FL_THERM_SHUT] | flags_q[FL_THERM_WARN];
		regAny   = flags_q[FL_REG_UV] | flags_q[FL_REG_OC];
		// Supply reset is a status, not a fault, so the summary leaves it out.
		psAny    = |flags_q[FL_OVERVOLT:FL_CP_UV];
		lockAny  = flags_q[FL_ABNORMAL_SPEED_LOCK] | flags_q[FL_SYNC_LOST]
		           | flags_q[FL_MOTOR_ABSENT] | flags_q[FL_CYCLE_ILIM];
		clAny    = |flags_q[FL_POS_FREQ:FL_WDOG];

		psImage                               = FAULT_RESET_VALUE;
		psImage[PS_DRIVER_FAULT]              = psAny;
		psImage[PS_REG_FAULT]                 = regAny;
		psImage[PS_OC_ANY]                    = ocAny;
		psImage[PS_POR_INV]                   = ~flags_q[FL_POR];
		psImage[PS_OVERVOLT]                  = flags_q[FL_OVERVOLT];
		psImage[PS_THERMAL_ANY]               = thermAny;
		psImage[PS_THERMAL_WARN]              = flags_q[FL_THERM_WARN];
		psImage[PS_THERMAL_SHUT]              = flags_q[FL_THERM_SHUT];
		psImage[PS_OC_SW_HI:PS_OC_SW_LO]      = flags_q[FL_SW_HI:FL_SW_LO];
		psImage[PS_MEM_ERR]                   = flags_q[FL_MEM_ERR];
		psImage[PS_REG_OC]                    = flags_q[FL_REG_OC];
		psImage[PS_REG_UV]                    = flags_q[FL_REG_UV];
		psImage[PS_CP_UV]                     = flags_q[FL_CP_UV];

		clImage                               = FAULT_RESET_VALUE;
		clImage[CL_CTRL_FAULT]                = clAny;
		clImage[CL_POS_FREQ]                  = flags_q[FL_POS_FREQ];
		clImage[CL_POS_T1]                    = flags_q[FL_POS_T1];
		clImage[CL_POS_T2]                    = flags_q[FL_POS_T2];
		clImage[CL_ABNORMAL_SPEED_LOCK]                 = flags_q[FL_ABNORMAL_SPEED_LOCK];
		clImage[CL_SYNC_LOST]                 = flags_q[FL_SYNC_LOST];
		clImage[CL_MOTOR_ABSENT]              = flags_q[FL_MOTOR_ABSENT];
		clImage[CL_LOCK_ANY]                  = lockAny;
		clImage[CL_CYCLE_ILIM]                = flags_q[FL_CYCLE_ILIM];
		clImage[CL_LOCK_ILIM]                 = flags_q[FL_LOCK_ILIM];
		clImage[CL_MOTOR_UV]                  = flags_q[FL_MOTOR_UV];
		clImage[CL_MOTOR_OV]                  = flags_q[FL_MOTOR_OV];
		clImage[CL_WDOG_TIMEOUT]              = flags_q[FL_WDOG];
		clImage[CL_SELFTEST_EN]               = selftestEn;
		clImage[CL_SELFTEST_PASS]             = selftestOk;
		clImage[CL_APP_RESET_OK]              = appOk;
	end

	//--------------------------------------------------------------------
	// Read port
	//--------------------------------------------------------------------
	logic [REG_W-1:0] rdata_q;
	logic [REG_W-1:0] rdata_d;
	logic             rvalid_q;
	logic             rvalid_d;
	logic             clrPulse_q;
	logic             clrPulse_d;

	always_comb begin
		rvalid_d   = regRead;
		clrPulse_d = clearCmd;
		rdata_d    = rdata_q;
		if (regRead) begin
			case (regAddr)
				ADDR_POWER_STAGE_FAULT:   rdata_d = psImage;
				ADDR_CONTROL_LOOP_FAULT:  rdata_d = clImage;
				ADDR_SYSTEM_STATUS_ONE:   rdata_d = systemStatusOne;
				ADDR_SYSTEM_STATUS_TWO:   rdata_d = systemStatusTwo;
				ADDR_SYSTEM_STATUS_THREE: rdata_d = systemStatusThree;
				default:                  rdata_d = FAULT_RESET_VALUE;
			endcase
		end
	end

	// Writes to the fault registers have no effect; they are read-only.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_q    <= FAULT_RESET_VALUE;
			rvalid_q   <= 1'b0;
			clrPulse_q <= 1'b0;
		end else begin
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
			clrPulse_q <= clrPulse_d;
		end
	end

	assign regRdata            = rdata_q;
	assign regRvalid           = rvalid_q;
	assign clearAllFaultsPulse = clrPulse_q;

endmodule : mdfs_fault_status

/* File: verif/mdfs_fault_status_properties.sv */
// Purpose: Port checks for the fault status register bank.
// Assumes: Read data comes one cycle after the read strobe.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ns
module mdfs_fault_status_properties
	import mdfs_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regRead,
	input wire logic              regWrite,
	input wire logic [REG_W-1:0]  regWdata,
	input wire logic [REG_W-1:0]  regRdata,
	input wire logic              regRvalid,
	input wire logic              clearAllFaultsPulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [ADDR_W-1:0] rdAddr_q;
	wire psRd = regRvalid && rdAddr_q == ADDR_POWER_STAGE_FAULT;
	wire clRd = regRvalid && rdAddr_q == ADDR_CONTROL_LOOP_FAULT;
	wire clrCmd = regWrite && regAddr == ADDR_ALGO_CONTROL && regWdata[ALGO_CLEAR_FAULTS];
	always_ff @(posedge sys_clk) begin
		rdAddr_q <= regAddr;
	end
	property p_rvalid; 1 |=> regRvalid == $past(regRead); endproperty
	property p_clear; 1 |=> clearAllFaultsPulse == $past(clrCmd); endproperty
	property p_psOr; psRd && |{regRdata[30], regRdata[28], regRdata[26:16], regRdata[14:11]}
		|-> regRdata[31]; endproperty
	property p_ocAny; psRd && |regRdata[21:16] |-> regRdata[28]; endproperty
	property p_therm; psRd |-> regRdata[25] == (regRdata[23] | regRdata[22]); endproperty
	property p_regFlt; psRd |-> regRdata[30] == (regRdata[13] | regRdata[12]); endproperty
	property p_rsvPs; psRd |-> {regRdata[29], regRdata[24], regRdata[15], regRdata[10:0]} == '0;
	endproperty
	property p_rsvCl; clRd |-> {regRdata[30], regRdata[26:24], regRdata[14:3]} == '0; endproperty
	property p_clOr; clRd && |regRdata[29:15] |-> regRdata[31]; endproperty
	property p_lock; clRd && (regRdata[23] | regRdata[22]) |-> regRdata[20]; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer timing");
	a_clear: assert property (p_clear) else $error("clear pulse timing");
	a_psOr: assert property (p_psOr) else $error("power summary bit");
	a_ocAny: assert property (p_ocAny) else $error("overcurrent summary");
	a_therm: assert property (p_therm) else $error("thermal summary");
	a_regFlt: assert property (p_regFlt) else $error("regulator summary");
	a_rsvPs: assert property (p_rsvPs) else $error("power reserved bits");
	a_rsvCl: assert property (p_rsvCl) else $error("control reserved bits");
	a_clOr: assert property (p_clOr) else $error("control summary bit");
	a_lock: assert property (p_lock) else $error("lock summary bit");
	c_clear: cover property (clrCmd ##1 clearAllFaultsPulse);
	c_psFlt: cover property (psRd && regRdata[31]);
	c_clFlt: cover property (clRd && regRdata[20]);
endmodule : mdfs_fault_status_properties

bind mdfs_fault_status mdfs_fault_status_properties u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
	.regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
	.clearAllFaultsPulse(clearAllFaultsPulse)
);

/* File: verif/mdfs_host.sv */
// Purpose: Host side of the register port.
// Assumes: One strobe per access, answer awaited before the next.
// Notes:   Released address and data are inverted so stale values never match.
`timescale 1ns/1ns
module mdfs_host
	import mdfs_pkg::*;
(
	input wire logic              sys_clk,
	output logic     [ADDR_W-1:0] regAddr,
	output logic                  regRead,
	output logic                  regWrite,
	output logic     [REG_W-1:0]  regWdata,
	input wire logic              regRvalid,
	input wire logic [REG_W-1:0]  regRdata
);
	initial begin
		regAddr = '0;
		regRead = 1'b0;
		regWrite = 1'b0;
		regWdata = '0;
	end
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
		int n;
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			regRead <= 1'b0;
			n++;
		end while (regRvalid !== 1'b1 && n < 4);
		if (regRvalid === 1'b1) begin
			d = regRdata;
		end else begin
			d = 'x;
		end
		regAddr <= ~a;
	endtask : rd
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask : wr
endmodule : mdfs_host

/* File: verif/test_motor_driver_fault_status.sv */
// Purpose: Self-checking bench of the fault status bank.
// Assumes: Fault levels reach read data within five cycles.
// Notes:   pf and cf pack the power-stage and controller inputs.
`timescale 1ns/1ns
module test_motor_driver_fault_status
	import mdfs_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [13:0] pf = '0;
	logic [13:0] cf = '0;
	logic [31:0] st1 = '0;
	logic [31:0] st2 = '0;
	logic [31:0] st3 = '0;
	logic [7:0] regAddr;
	logic regRead, regWrite, regRvalid, clrPulse;
	logic [31:0] regWdata, regRdata;
	int fails = 0;
	int numChecks = 0;
	always #5 sys_clk = ~sys_clk;
	mdfs_host HOST (.sys_clk(sys_clk), .regAddr(regAddr), .regRead(regRead),
		.regWrite(regWrite), .regWdata(regWdata), .regRvalid(regRvalid), .regRdata(regRdata));
	mdfs_fault_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
		.regRvalid(regRvalid), .supplyPorDetect(pf[0]), .supplyOvervoltage(pf[1]),
		.thermalWarning(pf[2]), .thermalShutdown(pf[3]), .otpMemoryError(pf[4]),
		.regulatorOvercurrent(pf[5]), .regulatorUndervoltage(pf[6]),
		.chargePumpUndervoltage(pf[7]), .overcurrentSwitch(pf[13:8]),
		.positionDetectFreqFault(cf[0]), .positionDetectTiming1Fault(cf[1]),
		.positionDetectTiming2Fault(cf[2]), .abnormalSpeedLock(cf[3]), .syncLostLock(cf[4]),
		.motorAbsentFault(cf[5]), .cycleCurrentLimitFault(cf[6]),
		.lockCurrentLimitFault(cf[7]), .motorUndervoltageFault(cf[8]),
		.motorOvervoltageFault(cf[9]), .hostWatchdogTimeout(cf[10]),
		.selftestEnabledCfg(cf[11]), .selftestPass(cf[12]), .appResetOk(cf[13]),
		.systemStatusOne(st1), .systemStatusTwo(st2), .systemStatusThree(st3),
		.clearAllFaultsPulse(clrPulse));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		HOST.rd(a, d);
		check(what, d, exp);
	endtask : rdChk
	task automatic setIn(input logic [13:0] p, input logic [13:0] c);
		@(posedge sys_clk);
		pf <= p;
		cf <= c;
		repeat (5) @(posedge sys_clk);
	endtask : setIn
	task automatic clearCmd(input logic [31:0] d, input logic exp);
		HOST.wr(ADDR_ALGO_CONTROL, d);
		@(posedge sys_clk);
		check("clear pulse", {31'h0, clrPulse}, {31'h0, exp});
	endtask : clearCmd
	task automatic printVerdict;
		if (fails == 0 && numChecks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : printVerdict
	task automatic tReset;
		rdChk(ADDR_POWER_STAGE_FAULT, 32'h00000000, "power reset");
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h00000000, "control reset");
	endtask : tReset
	task automatic tPower;
		setIn(14'h2104, 14'h0);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'h92A10000, "power set");
		setIn(14'h0, 14'h0);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'h92A10000, "power held");
		clearCmd(32'h20000000, 1'b1);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'h08000000, "power cleared");
	endtask : tPower
	task automatic tSupply;
		setIn(14'h1EFB, 14'h0);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'hD65E7800, "supply set");
		clearCmd(32'h20000000, 1'b1);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'hD65E7800, "set wins");
		setIn(14'h0, 14'h0);
		HOST.wr(ADDR_POWER_STAGE_FAULT, 32'hFFFFFFFF);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'hD65E7800, "read only");
		clearCmd(32'hDFFFFFFF, 1'b0);
		clearCmd(32'h20000000, 1'b1);
		rdChk(ADDR_POWER_STAGE_FAULT, 32'h08000000, "supply cleared");
	endtask : tSupply
	task automatic tCtrl;
		setIn(14'h0, 14'h3C00);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h80008007, "watchdog");
		setIn(14'h0, 14'h3FFF);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'hB8FF8007, "all control");
		setIn(14'h0, 14'h0);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'hB8FF8000, "mirrors drop");
		clearCmd(32'h20000000, 1'b1);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h00000000, "control cleared");
		setIn(14'h0, 14'h0100);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h80020000, "no lock from uv");
		setIn(14'h0, 14'h0008);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h80920000, "speed lock");
		setIn(14'h0, 14'h0);
		clearCmd(32'h20000000, 1'b1);
		rdChk(ADDR_CONTROL_LOOP_FAULT, 32'h00000000, "lock cleared");
	endtask : tCtrl
	task automatic tSys;
		@(posedge sys_clk);
		st1 <= 32'h1234ABCD;
		st2 <= 32'h5A5AC3C3;
		st3 <= 32'hFEDC0123;
		rdChk(ADDR_SYSTEM_STATUS_ONE, 32'h1234ABCD, "status one");
		rdChk(ADDR_SYSTEM_STATUS_TWO, 32'h5A5AC3C3, "status two");
		rdChk(ADDR_SYSTEM_STATUS_THREE, 32'hFEDC0123, "status three");
		rdChk(8'hE8, 32'h00000000, "unmapped");
		rdChk(ADDR_ALGO_CONTROL, 32'h00000000, "write only");
	endtask : tSys
	initial begin
		#200000;
		fails++;
		printVerdict();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		tReset();
		tPower();
		tSupply();
		tCtrl();
		tSys();
		printVerdict();
	end
endmodule : test_motor_driver_fault_status
